// [src/ghsp_params.svh]
// Constants for the host serial port: timing counts, framing and layout.
// Assumes a 10 MHz system clock; included by ghsp_port only.
`ifndef GHSP_PARAMS_SVH
`define GHSP_PARAMS_SVH
`define GHSP_CLK_HZ 10000000
`define GHSP_LOCK_MS 2100
`define GHSP_LOCK_CYC ((`GHSP_CLK_HZ / 1000) * `GHSP_LOCK_MS)
`define GHSP_BAUD_PKT 9600
`define GHSP_BAUD_TXT 4800
`define GHSP_DIV_PKT (`GHSP_CLK_HZ / (`GHSP_BAUD_PKT * 16))
`define GHSP_DIV_TXT (`GHSP_CLK_HZ / (`GHSP_BAUD_TXT * 16))
`define GHSP_FIFO_DEPTH 32
`define GHSP_FIFO_AW 5
`define GHSP_CMD_PORTCFG 8'hbc
`define GHSP_CMD_SAVE 8'h8e
`define GHSP_SUB_SAVE 8'h26
`define GHSP_DLE 8'h10
`define GHSP_ETX 8'h03
`define GHSP_A_CTRL 12'h000
`define GHSP_A_STAT 12'h004
`define GHSP_A_TXD 12'h008
`define GHSP_A_RXD 12'h00c
`define GHSP_A_FLASH 12'h010
`define GHSP_CTRL_TEXT 0
`define GHSP_CTRL_FLVALID 1
`define GHSP_CTRL_BBLOST 2
`endif

// [src/ghsp_pkg.sv]
// Types shared by the host serial port modules.
// Assumes ghsp_params.svh is on the include path.
package ghsp_pkg;
    // Port settings as held in battery-backed RAM and in flash.
    typedef struct packed {
        logic text_mode;
    } ghsp_cfg_t;
    // A received character with its error status.
    typedef struct packed {
        logic [7:0] data;
        logic err;
    } ghsp_rxc_t;
    // Command parser states.
    typedef enum logic [4:0] {
        PS_IDLE = 5'b00001,
        PS_ID = 5'b00010,
        PS_BODY = 5'b00100,
        PS_DLE = 5'b01000,
        PS_DROP = 5'b10000
    } ghsp_ps_t;
endpackage : ghsp_pkg

// [src/ghsp_fifo.sv]
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module ghsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_data,
    input wire logic i_valid,
    output logic o_ready,
    output logic [WIDTH-1:0] o_data,
    output logic o_valid,
    input wire logic i_ready
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } ff_t;
    ff_t s_r, s_nxt;
    logic push, pop;

    // Count-based full and empty give honest back-pressure.
    always_comb begin
        o_ready = (s_r.cnt != (AW+1)'(DEPTH));
        o_valid = (s_r.cnt != '0);
        o_data = s_r.mem[s_r.rp];
        push = i_valid && o_ready;
        pop = o_valid && i_ready;
        s_nxt = s_r;
        if (push) begin
            s_nxt.mem[s_r.wp] = i_data;
            s_nxt.wp = s_r.wp + 1'b1;
        end
        if (pop) begin
            s_nxt.rp = s_r.rp + 1'b1;
        end
        if (push && !pop) begin
            s_nxt.cnt = s_r.cnt + 1'b1;
        end else if (pop && !push) begin
            s_nxt.cnt = s_r.cnt - 1'b1;
        end
    end

    // State register.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : ghsp_fifo

// [src/ghsp_rx.sv]
// Serial receiver, 8 data bits, optional odd parity, one stop bit.
// Assumes i_tick at 16 times the bit rate and a synchronous line input.
`timescale 1ns/10ps
module ghsp_rx (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_tick,
    input wire logic i_parity,
    input wire logic i_line,
    output ghsp_pkg::ghsp_rxc_t o_char,
    output logic o_stb
);
    import ghsp_pkg::*;
    typedef struct packed {
        logic busy;
        logic [3:0] sub;
        logic [3:0] bitn;
        logic [8:0] sh;
        logic stb;
        ghsp_rxc_t ch;
    } rx_t;
    rx_t s_r, s_nxt;
    logic [3:0] last;

    // Samples mid-bit; last bit index is the stop bit, 10 with parity or 9 without.
    always_comb begin
        s_nxt = s_r;
        s_nxt.stb = 1'b0;
        last = i_parity ? 4'ha : 4'h9;
        if (!s_r.busy) begin
            if (!i_line && i_tick) begin
                s_nxt.busy = 1'b1;
                s_nxt.sub = 4'h0;
                s_nxt.bitn = 4'h0;
            end
        end else if (i_tick) begin
            s_nxt.sub = s_r.sub + 4'h1;
            if (s_r.sub == 4'h7) begin
                if (s_r.bitn == 4'h0 && i_line) begin
                    s_nxt.busy = 1'b0;
                end else if (s_r.bitn == last) begin
                    s_nxt.busy = 1'b0;
                    s_nxt.stb = 1'b1;
                    s_nxt.ch.data = s_r.sh[7:0];
                    // Framing error, or parity not odd over data+parity.
                    s_nxt.ch.err = !i_line ||
                        (i_parity && !(^s_r.sh));
                end else begin
                    if (s_r.bitn != 4'h0) begin
                        s_nxt.sh = i_parity ? {i_line, s_r.sh[8:1]}
                                            : {1'b0, i_line, s_r.sh[7:1]};
                    end
                    s_nxt.bitn = s_r.bitn + 4'h1;
                end
            end
        end
    end

    assign o_char = s_r.ch;
    assign o_stb = s_r.stb;

    // State register.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : ghsp_rx

// [src/ghsp_port.sv]
// Host serial port of the receiver: one UART, command parser, APB regs.
// Assumes a 10 MHz clock, synchronous pins and an APB master.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "ghsp_params.svh"
module ghsp_port #(
    parameter int LOCK_CYC = `GHSP_LOCK_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_rxd,
    output logic o_txd,
    output logic o_cmd_stb,
    output logic [7:0] o_cmd_id,
    output logic [7:0] o_cmd_arg
);
    import ghsp_pkg::*;

    typedef struct packed {
        logic [31:0] lock;
        logic locked;
        ghsp_cfg_t battery_backed_ram;
        ghsp_cfg_t flash;
        logic fl_valid;
        logic [9:0] div;
        logic tick;
        ghsp_ps_t ps;
        logic [7:0] id;
        logic [7:0] arg;
        logic [3:0] nbody;
        logic hold_cfg;
        logic cfg_pend;
        logic cmd_stb;
        logic [7:0] cmd_id;
        logic [7:0] cmd_arg;
        logic tx_busy;
        logic [3:0] tx_sub;
        logic [3:0] tx_bit;
        logic [10:0] tx_sh;
        logic txd;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [7:0] rxd_last;
        logic dropped;
    } st_t;
    st_t s_r, s_nxt;

    ghsp_rxc_t rx_char;
    logic rx_stb;
    logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
    logic [7:0] f_out_data;
    logic good;
    logic acc;
    logic [9:0] div_max;
    logic par_bit;

    // The receive side, sharing the single line pair with transmit.
    ghsp_rx u_rx (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_tick(s_r.tick),
        .i_parity(!s_r.battery_backed_ram.text_mode),
        .i_line(i_rxd),
        .o_char(rx_char),
        .o_stb(rx_stb)
    );

    // Report bytes written by software wait here for the transmitter.
    ghsp_fifo #(
        .WIDTH(8),
        .DEPTH(`GHSP_FIFO_DEPTH),
        .AW(`GHSP_FIFO_AW)
    ) u_txq (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_data(i_pwdata[7:0]),
        .i_valid(f_in_valid),
        .o_ready(f_in_ready),
        .o_data(f_out_data),
        .o_valid(f_out_valid),
        .i_ready(f_out_ready)
    );

    // APB access phase; every access takes one wait state and completes in its second access cycle.
    assign acc = i_psel && i_penable && !s_r.pready;
    assign f_in_valid = acc && i_pwrite && (i_paddr == `GHSP_A_TXD);
    assign f_out_ready = !s_r.tx_busy && s_r.tick;
    // A good character is error-free, after lockout, in packet mode.
    assign good = rx_stb && !rx_char.err
        && !s_r.locked
        && !s_r.battery_backed_ram.text_mode;
    assign div_max = s_r.battery_backed_ram.text_mode ? 10'(`GHSP_DIV_TXT - 1)
                                         : 10'(`GHSP_DIV_PKT - 1);
    assign par_bit = ~^f_out_data;

    // Next-state logic for the whole port.
    always_comb begin
        s_nxt = s_r;
        s_nxt.cmd_stb = 1'b0;
        s_nxt.pready = 1'b0;
        s_nxt.pslverr = 1'b0;
        // Start-up lockout counter after reset.
        if (s_r.locked) begin
            if (s_r.lock == 32'(LOCK_CYC - 1)) begin
                s_nxt.locked = 1'b0;
            end else begin
                s_nxt.lock = s_r.lock + 32'h1;
            end
        end
        // Oversample divider; rate follows the active protocol.
        s_nxt.tick = 1'b0;
        if (s_r.div >= div_max) begin
            s_nxt.div = 10'h0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.div = s_r.div + 10'h1;
        end
        // Framed command parser: DLE id body DLE ETX.
        if (rx_stb && !good) begin
            s_nxt.dropped = 1'b1;
        end
        if (s_r.locked && rx_stb) begin
            s_nxt.ps = PS_DROP;
        end else if (good) begin
            s_nxt.rxd_last = rx_char.data;
            case (s_r.ps)
                PS_IDLE: begin
                    if (rx_char.data == `GHSP_DLE) begin
                        s_nxt.ps = PS_ID;
                    end
                end
                PS_DROP: begin
                    if (rx_char.data == `GHSP_DLE) begin
                        s_nxt.ps = PS_ID;
                    end
                end
                PS_ID: begin
                    s_nxt.id = rx_char.data;
                    s_nxt.nbody = 4'h0;
                    s_nxt.ps = PS_BODY;
                end
                PS_BODY: begin
                    if (rx_char.data == `GHSP_DLE) begin
                        s_nxt.ps = PS_DLE;
                    end else begin
                        if (s_r.nbody == 4'h0) begin
                            s_nxt.arg = rx_char.data;
                        end
                        if (s_r.nbody != 4'hf) begin
                            s_nxt.nbody = s_r.nbody + 4'h1;
                        end
                    end
                end
                PS_DLE: begin
                    if (rx_char.data == `GHSP_ETX) begin
                        s_nxt.ps = PS_IDLE;
                        s_nxt.cmd_stb = 1'b1;
                        s_nxt.cmd_id = s_r.id;
                        s_nxt.cmd_arg = s_r.arg;
                        if (s_r.id == `GHSP_CMD_PORTCFG) begin
                            // Applied once the transmitter is idle, after the current character.
                            s_nxt.hold_cfg = s_r.arg[0];
                            s_nxt.cfg_pend = 1'b1;
                        end else if (s_r.id == `GHSP_CMD_SAVE &&
                                     s_r.arg == `GHSP_SUB_SAVE) begin
                            s_nxt.flash = s_r.battery_backed_ram;
                            s_nxt.fl_valid = 1'b1;
                        end
                    end else begin
                        if (s_r.nbody == 4'h0) begin
                            s_nxt.arg = rx_char.data;
                        end
                        s_nxt.nbody = s_r.nbody + 4'h1;
                        s_nxt.ps = PS_BODY;
                    end
                end
                default: s_nxt.ps = PS_IDLE;
            endcase
        end
        // Apply a pending port command's framing only while the transmitter is idle.
        if (s_r.cfg_pend && !s_r.tx_busy) begin
            s_nxt.battery_backed_ram.text_mode = s_r.hold_cfg;
            s_nxt.cfg_pend = 1'b0;
        end
        // Transmitter: start, 8 data LSB first, odd parity unless text.
        if (!s_r.tx_busy) begin
            s_nxt.txd = 1'b1;
            if (f_out_valid && s_r.tick) begin
                s_nxt.tx_busy = 1'b1;
                s_nxt.tx_sub = 4'h0;
                s_nxt.tx_bit = 4'h0;
                s_nxt.tx_sh = s_r.battery_backed_ram.text_mode
                    ? {2'b11, f_out_data, 1'b0}
                    : {1'b1, par_bit, f_out_data, 1'b0};
            end
        end else if (s_r.tick) begin
            s_nxt.txd = s_r.tx_sh[0];
            s_nxt.tx_sub = s_r.tx_sub + 4'h1;
            if (s_r.tx_sub == 4'hf) begin
                s_nxt.tx_sh = {1'b1, s_r.tx_sh[10:1]};
                s_nxt.tx_bit = s_r.tx_bit + 4'h1;
                if (s_r.tx_bit ==
                    (s_r.battery_backed_ram.text_mode ? 4'h9 : 4'ha)) begin
                    s_nxt.tx_busy = 1'b0;
                end
            end
        end
        // APB register access.
        if (acc) begin
            s_nxt.pready = 1'b1;
            s_nxt.prdata = 32'h0;
            if (i_paddr == `GHSP_A_CTRL) begin
                if (i_pwrite) begin
                    s_nxt.battery_backed_ram.text_mode = i_pwdata[`GHSP_CTRL_TEXT];
                    if (i_pwdata[`GHSP_CTRL_BBLOST]) begin
                        // Battery RAM lost: flash copy or default.
                        s_nxt.battery_backed_ram = s_r.fl_valid ? s_r.flash
                                                   : ghsp_cfg_t'(1'b0);
                    end
                end else begin
                    s_nxt.prdata[`GHSP_CTRL_TEXT] = s_r.battery_backed_ram.text_mode;
                    s_nxt.prdata[`GHSP_CTRL_FLVALID] = s_r.fl_valid;
                end
            end else if (i_paddr == `GHSP_A_STAT) begin
                if (!i_pwrite) begin
                    s_nxt.prdata = {25'h0, s_r.dropped, s_r.cfg_pend,
                        s_r.tx_busy, f_out_valid, !f_in_ready,
                        s_r.fl_valid, s_r.locked};
                end else if (i_pwdata[6] && !(rx_stb && !good)) begin
                    s_nxt.dropped = 1'b0;
                end
            end else if (i_paddr == `GHSP_A_TXD) begin
                if (!i_pwrite) begin
                    s_nxt.prdata = {31'h0, f_in_ready};
                end else if (!f_in_ready) begin
                    s_nxt.pslverr = 1'b1;
                end
            end else if (i_paddr == `GHSP_A_RXD) begin
                s_nxt.prdata = {24'h0, s_r.rxd_last};
                s_nxt.pslverr = i_pwrite;
            end else if (i_paddr == `GHSP_A_FLASH) begin
                s_nxt.prdata = {30'h0, s_r.fl_valid,
                                s_r.flash.text_mode};
                s_nxt.pslverr = i_pwrite;
            end else begin
                s_nxt.pslverr = 1'b1;
            end
        end
    end

    assign o_prdata = s_r.prdata;
    assign o_pready = s_r.pready;
    assign o_pslverr = s_r.pslverr;
    assign o_txd = s_r.txd;
    assign o_cmd_stb = s_r.cmd_stb;
    assign o_cmd_id = s_r.cmd_id;
    assign o_cmd_arg = s_r.cmd_arg;

    // State register; reset clears the flash contents and the rest, but sets locked and txd high and ps to PS_IDLE.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            s_r <= '0;
            s_r.locked <= 1'b1;
            s_r.txd <= 1'b1;
            s_r.ps <= PS_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : ghsp_port

// [tb/ghsp_port_sva.sv]
// Checker for the host serial port top: APB timing, command strobe, line.
// Assumes binding to ghsp_port, one clock, synchronous active-high reset.
`timescale 1ns/10ps
module ghsp_port_chk #(
    parameter int LOCK_CYC = 2000
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_rxd,
    input wire logic o_txd,
    input wire logic o_cmd_stb,
    input wire logic [7:0] o_cmd_id,
    input wire logic [7:0] o_cmd_arg
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    logic [31:0] age_r;
    // Counts cycles since reset release, so the lockout can be judged.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) age_r <= 32'h0;
        else if (age_r < LOCK_CYC) age_r <= age_r + 32'h1;
    end
    sequence s_req;
        i_psel && i_penable && !o_pready;
    endsequence
    sequence s_bad;
        s_req ##0 ((i_paddr > 12'h010) ||
            (i_pwrite && (i_paddr == 12'h00c || i_paddr == 12'h010)));
    endsequence
    sequence s_good_rd;
        s_req ##0 (!i_pwrite && i_paddr <= 12'h010 && i_paddr[1:0] == 2'h0);
    endsequence
    AST_PREADY_WAIT: assert property (s_req |=> o_pready)
        else $error("pready late");
    AST_PREADY_PULSE: assert property (o_pready |=> !o_pready)
        else $error("pready longer than one cycle");
    AST_PREADY_CAUSE: assert property (o_pready |->
        $past(i_psel && i_penable))
        else $error("pready without access");
    AST_ERR_REFUSE: assert property (s_bad |=> o_pslverr)
        else $error("refused access without pslverr");
    AST_ERR_GOOD: assert property (s_good_rd |=> !o_pslverr)
        else $error("pslverr on mapped read");
    AST_ERR_ONLY_READY: assert property (o_pslverr |-> o_pready)
        else $error("pslverr without pready");
    AST_LOCKOUT: assert property (o_cmd_stb |-> age_r >= LOCK_CYC)
        else $error("command accepted in lockout");
    AST_CMD_PULSE: assert property (o_cmd_stb |=> !o_cmd_stb)
        else $error("command strobe too long");
    AST_CMD_HOLD: assert property (o_cmd_stb |=>
        ($stable(o_cmd_id) && $stable(o_cmd_arg))[*4])
        else $error("command id or arg moved");
    AST_TX_IDLE: assert property ($fell(i_rst) |-> o_txd)
        else $error("serial out not idle high after reset");
    AST_TX_START: assert property ($fell(o_txd) |=> !o_txd[*8])
        else $error("start bit too short");
endmodule : ghsp_port_chk

bind ghsp_port ghsp_port_chk #(.LOCK_CYC(LOCK_CYC)) ghsp_port_chk_inst (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_rxd(i_rxd), .o_txd(o_txd),
    .o_cmd_stb(o_cmd_stb), .o_cmd_id(o_cmd_id), .o_cmd_arg(o_cmd_arg));

// [tb/ghsp_host.sv]
// Host UART model: sends and receives 8 data bits, odd parity, one stop.
// Assumes the design divides to 1040 clocks a bit at 9600 baud.
`timescale 1ns/10ps
module ghsp_host #(
    parameter int BIT_CYC = 1040
) (
    input wire logic i_clk_sys,
    input wire logic i_line,
    output logic o_line
);
    logic [7:0] rx_byte;
    logic rx_ok;
    logic [10:0] fr;
    // The line idles high between frames.
    initial begin
        o_line = 1'b1;
        rx_byte = 8'h00;
        rx_ok = 1'b0;
    end
    // Sends one frame LSB first; bad_par inverts the parity bit.
    task automatic send(input logic [7:0] b, input logic bad_par);
        logic [10:0] f;
        f = {1'b1, (~^b) ^ bad_par, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            o_line <= f[i];
            repeat (BIT_CYC) @(posedge i_clk_sys);
        end
    endtask : send
    // Samples each bit mid-cell and judges parity and stop bit.
    always begin
        @(negedge i_line);
        repeat (BIT_CYC / 2) @(posedge i_clk_sys);
        for (int i = 0; i < 11; i++) begin
            fr[i] = i_line;
            if (i < 10) repeat (BIT_CYC) @(posedge i_clk_sys);
        end
        rx_byte = fr[8:1];
        rx_ok = !fr[0] && fr[10] && (^fr[9:1]);
    end
endmodule : ghsp_host

// [tb/gps_host_serial_port_test.sv]
// Testbench for the host serial port: APB tasks plus a host UART model.
// Assumes ghsp_port, ghsp_host and the checker are compiled before it.
`timescale 1ns/10ps
module gps_host_serial_port_test;
    localparam int LOCK = 12000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, rxd, txd, cmd_stb, er;
    logic [7:0] cmd_id, cmd_arg, id_seen, arg_seen;
    logic [7:0] pkt [5] = '{8'h10, 8'h8e, 8'h26, 8'h10, 8'h03};
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int n_cmd = 0;
    // Clock of 100 ns period.
    always #50 clk = ~clk;
    ghsp_port #(.LOCK_CYC(LOCK)) ghsp_port_inst (
        .i_clk_sys(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_rxd(rxd), .o_txd(txd), .o_cmd_stb(cmd_stb), .o_cmd_id(cmd_id),
        .o_cmd_arg(cmd_arg));
    ghsp_host ghsp_host_inst (.i_clk_sys(clk), .i_line(txd), .o_line(rxd));
    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    // Compares one value and counts it.
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One APB transfer; read data and error are taken at the pready edge.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Captures every parsed command and cuts a hang short.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cmd_stb === 1'b1) begin
            n_cmd <= n_cmd + 1;
            id_seen <= cmd_id;
            arg_seen <= cmd_arg;
        end
        if (cyc == 98000) begin
            err_count++;
            final_report();
        end
    end
    // Main sequence of scenarios.
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        apb(1'b0, 12'h004, 32'h0);
        chk("locked", 32'h1, rd & 32'h1);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped err", 32'h1, 32'(er));
        apb(1'b1, 12'h00c, 32'h0);
        chk("rxd write err", 32'h1, 32'(er));
        ghsp_host_inst.send(8'h10, 1'b0);
        apb(1'b0, 12'h00c, 32'h0);
        chk("rxd in lockout", 32'h0, rd);
        repeat (1000) @(posedge clk);
        apb(1'b0, 12'h004, 32'h0);
        chk("unlocked", 32'h0, rd & 32'h1);
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b0, 12'h000, 32'h0);
        chk("text mode", 32'h1, rd & 32'h1);
        apb(1'b1, 12'h000, 32'h4);
        apb(1'b0, 12'h000, 32'h0);
        chk("default mode", 32'h0, rd);
        apb(1'b1, 12'h008, 32'h5a);
        foreach (pkt[i]) ghsp_host_inst.send(pkt[i], 1'b0);
        repeat (20) @(posedge clk);
        chk("cmd count", 32'h1, 32'(n_cmd));
        chk("cmd id", 32'h8e, 32'(id_seen));
        chk("cmd arg", 32'h26, 32'(arg_seen));
        chk("tx byte", 32'h5a, 32'(ghsp_host_inst.rx_byte));
        chk("tx frame", 32'h1, 32'(ghsp_host_inst.rx_ok));
        apb(1'b0, 12'h010, 32'h0);
        chk("flash copy", 32'h2, rd);
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl text", 32'h3, rd);
        apb(1'b1, 12'h000, 32'h4);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl restored", 32'h2, rd);
        ghsp_host_inst.send(8'h55, 1'b1);
        apb(1'b0, 12'h00c, 32'h0);
        chk("rxd bad parity", 32'h3, rd);
        chk("cmd count after", 32'h1, 32'(n_cmd));
        for (int i = 0; i < 34; i++) apb(1'b1, 12'h008, 32'(i));
        chk("full write err", 32'h1, 32'(er));
        apb(1'b0, 12'h004, 32'h0);
        chk("fifo full", 32'h4, rd & 32'h4);
        final_report();
    end
endmodule : gps_host_serial_port_test
